// >>> common/sfr_defines.vh
`ifndef SFR_DEFINES_VH
`define SFR_DEFINES_VH
// Command codes.
`define SFR_CMD_READ 8'h03
`define SFR_CMD_FAST 8'h0b
`define SFR_CMD_DOUT 8'h3b
`define SFR_CMD_DIO 8'hbb
`define SFR_CMD_QOUT 8'h6b
`define SFR_CMD_QIO 8'heb
`define SFR_CMD_DISC 8'h5a
// Dummy cycle counts (mode bit clocks are folded into these).
`define SFR_DUM_QIO 5'h09
`define SFR_DUM_QOUT 5'h07
`define SFR_DUM_DOUT 5'h08
`define SFR_DUM_DIO 5'h07
`define SFR_DUM_FAST 5'h08
`define SFR_DUM_DISC_SD 5'h08
`define SFR_DUM_DISC_Q 5'h0a
// Protocol encodings.
`define SFR_PROTO_EXT 2'h0
`define SFR_PROTO_DUAL 2'h1
`define SFR_PROTO_QUAD 2'h2
// Sizes.
`define SFR_ADDR_W 24
`define SFR_DISC_AW 11
`endif

// >>> design/sfr_disc_rom.v
`timescale 1ns/1ps
`include "sfr_defines.vh"
module sfr_disc_rom (
  // Table address and byte out.
  input wire [10:0] addr,
  output reg [7:0] data
);
  always @* begin
    case (addr)
      11'h000: data = 8'h53;
      11'h001: data = 8'h46;
      11'h002: data = 8'h44;
      11'h003: data = 8'h50;
      11'h004: data = 8'h00;
      11'h005: data = 8'h01;
      11'h006: data = 8'h00;
      11'h008: data = 8'h00;
      11'h009: data = 8'h00;
      11'h00a: data = 8'h01;
      11'h00b: data = 8'h09;
      11'h00c: data = 8'h30;
      11'h00d: data = 8'h00;
      11'h00e: data = 8'h00;
      11'h030: data = 8'he5;
      11'h031: data = 8'h20;
      11'h032: data = 8'hf1;
      11'h034: data = 8'hff;
      11'h035: data = 8'hff;
      11'h036: data = 8'hff;
      11'h037: data = 8'h01;
      11'h038: data = 8'h29;
      11'h039: data = 8'heb;
      11'h03a: data = 8'h27;
      11'h03b: data = 8'h6b;
      11'h03c: data = 8'h08;
      11'h03d: data = 8'h3b;
      11'h03e: data = 8'h27;
      11'h03f: data = 8'hbb;
      11'h040: data = 8'hff;
      11'h046: data = 8'h27;
      11'h047: data = 8'hbb;
      11'h04a: data = 8'h29;
      11'h04b: data = 8'heb;
      11'h04c: data = 8'h0c;
      11'h04d: data = 8'h20;
      11'h04e: data = 8'h10;
      11'h04f: data = 8'hd8;
      11'h050: data = 8'h00;
      11'h051: data = 8'h00;
      11'h052: data = 8'h00;
      11'h053: data = 8'h00;
      default: data = 8'hff;
    endcase
  end
endmodule

// >>> design/sfr_read_path.v
`timescale 1ns/1ps
`include "sfr_defines.vh"
// Notes on behaviour
// - Every memory read takes a full 24-bit byte address.
// - Host lowers select, then shifts command and three address bytes.
// - Incoming address bits are sampled on rising serial clock.
// - Address advances by one after each output byte.
// - Select high at any time stops output and ends the command.
// - Fast reads insert dummy cycles; basic read inserts none.
// - Basic read only in single lane; dual and quad allow only their reads.
// - Fast read behaves alike in all protocols, only lane count differs.
// - Quad I/O read EBh: 9 dummy cycles, one mode-bit count.
// - Quad output read 6Bh: 7 dummy cycles, one mode-bit count.
// - Dual output read 3Bh: 8 dummy cycles, no mode bits.
// - Dual I/O read BBh: 7 dummy cycles, one mode-bit count.
// - Full dual protocol read BBh: 7 dummy cycles.
// - Full quad protocol read EBh: 9 dummy cycles.
// - Table byte 40h reports all-dual and all-quad reads, reserved ones.
// - Table bytes 34h-37h give density minus one: FF FF FF 01.
// - First erase granule: exponent 0Ch, code 20h.
// - Second erase granule: exponent 10h, code D8h.
// - Table bytes 50h-53h read zero: no third or fourth granule.
// - Table read wraps at 2048 bytes to table address zero.
// - Table read has 8 dummy cycles, 10 in quad protocol.
module sfr_read_path #(
  parameter ADDR_W = 24
) (
  // Clock and reset.
  input wire core_clk,
  input wire rstn,
  // Serial link pins.
  input wire sel_n,
  input wire sclk,
  input wire [3:0] lane_in,
  output reg [3:0] lane_out,
  output reg [3:0] lane_oe,
  // Protocol selection, 0 single, 1 dual, 2 quad.
  input wire [1:0] proto,
  // Array read port.
  output reg [ADDR_W-1:0] mem_addr,
  input wire [7:0] mem_data,
  // Status.
  output reg busy
);
  localparam ST_IDLE = 3'h0;
  localparam ST_CMD = 3'h1;
  localparam ST_ADDR = 3'h2;
  localparam ST_DUMMY = 3'h3;
  localparam ST_DATA = 3'h4;
  localparam ST_IGN = 3'h5;

  reg [2:0] s_sel_q, s_clk_q;
  reg [7:0] s_lane_q;
  reg [2:0] state_q;
  reg [7:0] cmd_q;
  reg [ADDR_W-1:0] addr_q;
  reg [5:0] cnt_q;
  reg [4:0] dum_q;
  reg [2:0] lanes_q;
  reg disc_q;
  reg [7:0] sh_q;
  reg [2:0] bitc_q;
  wire [7:0] disc_byte;

  sfr_disc_rom u_rom (
    .addr(addr_q[10:0]),
    .data(disc_byte)
  );

  // Two-stage synchronisers; the third stage is only for edge detection.
  always @(posedge core_clk) begin
    if (!rstn) begin
      s_sel_q <= 3'h7;
      s_clk_q <= 3'h0;
      s_lane_q <= 8'h00;
    end else begin
      s_sel_q <= {s_sel_q[1:0], sel_n};
      s_clk_q <= {s_clk_q[1:0], sclk};
      s_lane_q <= {s_lane_q[3:0], lane_in};
    end
  end

  wire sel_hi = s_sel_q[1];
  wire rise = s_clk_q[1] & ~s_clk_q[2];
  wire fall = ~s_clk_q[1] & s_clk_q[2];
  wire [3:0] din = s_lane_q[7:4];
  wire [1:0] cmd_lanes = (proto == `SFR_PROTO_QUAD) ? 2'h2 : (proto == `SFR_PROTO_DUAL) ? 2'h1 : 2'h0;

  // Lane width per phase as a shift of 0, 1 or 2 bits.
  function [1:0] lw;
    input [2:0] l;
    begin
      lw = l[2] ? 2'h2 : (l[1] ? 2'h1 : 2'h0);
    end
  endfunction

  function [7:0] shin;
    input [7:0] v;
    input [2:0] l;
    input [3:0] d;
    begin
      case (lw(l))
        2'h2: shin = {v[3:0], d};
        2'h1: shin = {v[5:0], d[1:0]};
        default: shin = {v[6:0], d[0]};
      endcase
    end
  endfunction

  // Output enable mask for a data lane width; single-lane data leaves on lane one.
  function [3:0] oe_mask;
    input [2:0] l;
    begin
      case (lw(l))
        2'h2: oe_mask = 4'hf;
        2'h1: oe_mask = 4'h3;
        default: oe_mask = 4'h2;
      endcase
    end
  endfunction

  reg ok;
  reg [4:0] dum;
  reg [2:0] al, dl;
  always @* begin
    ok = 1'b1;
    dum = 5'h00;
    al = 3'h1;
    dl = 3'h1;
    case (sh_q)
      `SFR_CMD_READ: ok = (proto == `SFR_PROTO_EXT);
      `SFR_CMD_FAST: dum = `SFR_DUM_FAST;
      `SFR_CMD_DOUT: begin
        ok = (proto != `SFR_PROTO_QUAD);
        dum = `SFR_DUM_DOUT;
        dl = 3'h2;
      end
      `SFR_CMD_DIO: begin
        ok = (proto != `SFR_PROTO_QUAD);
        dum = `SFR_DUM_DIO;
        al = 3'h2;
        dl = 3'h2;
      end
      `SFR_CMD_QOUT: begin
        ok = (proto != `SFR_PROTO_DUAL);
        dum = `SFR_DUM_QOUT;
        dl = 3'h4;
      end
      `SFR_CMD_QIO: begin
        ok = (proto != `SFR_PROTO_DUAL);
        dum = `SFR_DUM_QIO;
        al = 3'h4;
        dl = 3'h4;
      end
      `SFR_CMD_DISC: dum = (proto == `SFR_PROTO_QUAD) ? `SFR_DUM_DISC_Q : `SFR_DUM_DISC_SD;
      default: ok = 1'b0;
    endcase
    // In dual or quad protocol every phase runs on the protocol's lanes.
    if (proto == `SFR_PROTO_DUAL) begin
      al = 3'h2;
      dl = 3'h2;
    end else if (proto == `SFR_PROTO_QUAD) begin
      al = 3'h4;
      dl = 3'h4;
    end
  end

  wire [2:0] clanes = {cmd_lanes == 2'h2, cmd_lanes == 2'h1, cmd_lanes == 2'h0};
  wire [7:0] sh_next = shin(sh_q, (state_q == ST_CMD) ? clanes : lanes_q, din);
  wire [7:0] out_byte = disc_q ? disc_byte : mem_data;
  wire [2:0] step = 3'h1 << lw(lanes_q);

  always @(posedge core_clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      cmd_q <= 8'h00;
      addr_q <= {ADDR_W{1'b0}};
      cnt_q <= 6'h00;
      dum_q <= 5'h00;
      lanes_q <= 3'h1;
      disc_q <= 1'b0;
      sh_q <= 8'h00;
      bitc_q <= 3'h0;
      lane_out <= 4'h0;
      lane_oe <= 4'h0;
      mem_addr <= {ADDR_W{1'b0}};
      busy <= 1'b0;
    end else if (sel_hi) begin
      // Select high ends any command and releases the lanes at once.
      state_q <= ST_IDLE;
      lane_oe <= 4'h0;
      busy <= 1'b0;
      cnt_q <= 6'h00;
      sh_q <= 8'h00;
      // A frame cut in mid-byte would otherwise start the next frame off its byte boundary.
      bitc_q <= 3'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_q <= ST_CMD;
          busy <= 1'b1;
          cnt_q <= 6'h00;
        end
        ST_CMD: if (rise) begin
          sh_q <= sh_next;
          if (cnt_q + 6'd1 == (6'd8 >> cmd_lanes)) begin
            cmd_q <= sh_next;
            cnt_q <= 6'h00;
            state_q <= ST_ADDR;
          end else begin
            cnt_q <= cnt_q + 6'd1;
          end
        end
        ST_ADDR: begin
          if (cnt_q == 6'h00 && !rise) begin
            sh_q <= cmd_q;
          end
          // Bit 5 of the counter marks the decode as done, whatever lanes the last frame used.
          if (cnt_q == 6'h00 && !rise) begin
            // First cycle after the command: latch the decoded address lane width and dummy count.
            if (!ok) begin
              state_q <= ST_IGN;
            end
            lanes_q <= al;
            dum_q <= dum;
            disc_q <= (cmd_q == `SFR_CMD_DISC);
            cnt_q <= 6'h20;
          end else if (rise) begin
            case (lw(lanes_q))
              2'h2: addr_q <= {addr_q[ADDR_W-5:0], din};
              2'h1: addr_q <= {addr_q[ADDR_W-3:0], din[1:0]};
              default: addr_q <= {addr_q[ADDR_W-2:0], din[0]};
            endcase
            if (cnt_q[4:0] + {2'h0, step} >= 5'd24) begin
              cnt_q <= 6'h00;
              lanes_q <= dl;
              state_q <= (dum_q == 5'h00) ? ST_DATA : ST_DUMMY;
            end else begin
              cnt_q <= {1'b1, cnt_q[4:0] + {2'h0, step}};
            end
          end
        end
        ST_DUMMY: if (rise) begin
          if (cnt_q[4:0] + 5'd1 == dum_q) begin
            state_q <= ST_DATA;
          end
          cnt_q <= cnt_q + 6'd1;
        end
        ST_DATA: begin
          mem_addr <= addr_q;
          if (fall) begin
            // Driving on the falling edge gives the host a half period of setup.
            case (lw(lanes_q))
              2'h2: lane_out <= bitc_q[2] ? out_byte[3:0] : out_byte[7:4];
              2'h1: lane_out <= {2'h0, out_byte[7 - {bitc_q[2:1], 1'b0} -: 2]};
              default: lane_out <= {2'h0, out_byte[3'd7 - bitc_q], 1'b0};
            endcase
            lane_oe <= oe_mask(lanes_q);
            if (bitc_q + step == 3'h0) begin
              bitc_q <= 3'h0;
              if (disc_q) begin
                addr_q <= {{(ADDR_W-11){1'b0}}, addr_q[10:0] + 11'h001};
              end else begin
                addr_q <= addr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
              end
            end else begin
              bitc_q <= bitc_q + step;
            end
          end
        end
        ST_IGN: lane_oe <= 4'h0;
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule

// >>> tb/sfr_host_model.sv
`timescale 1ns/1ps
module sfr_host_model (
  // Clock and link.
  input wire core_clk,
  input wire [1:0] proto,
  input wire [3:0] lane_out,
  input wire [3:0] lane_oe,
  output reg sel_n,
  output reg sclk,
  output wire [3:0] lane_in,
  // Last read bytes.
  output wire [31:0] got4,
  output reg oe_seen
);
  reg [3:0] host_q = 4'h0;
  reg [3:0] smp;
  reg [7:0] rx [0:7];
  assign got4 = {rx[0], rx[1], rx[2], rx[3]};
  // A released lane toggles every serial clock of the dummy and data phases so stale data never reads as valid.
  assign lane_in = (lane_oe & lane_out) | (~lane_oe & host_q);
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    oe_seen = 1'b0;
  end
  // Sampling just before the next fall gives the device synchroniser its full slack.
  task tick;
    begin
      repeat (4) @(negedge core_clk);
      sclk = 1'b1;
      repeat (4) @(negedge core_clk);
      smp = lane_out;
      oe_seen = oe_seen | (|lane_oe);
      sclk = 1'b0;
    end
  endtask
  task shift(input [23:0] v, input integer nb, input integer w);
    integer i;
    begin
      for (i = nb - w; i >= 0; i = i - w) begin
        host_q = 4'(v >> i) & ~(4'hf << w);
        tick;
      end
    end
  endtask
  task frame(input [7:0] cmd, input [23:0] a, input integer nb);
    integer cw, aw, dw, nd, j;
    reg [3:0] bits;
    begin
      cw = (proto == 2'h0) ? 1 : 2 * proto;
      aw = (proto != 2'h0) ? cw : (cmd == 8'hbb) ? 2 : (cmd == 8'heb) ? 4 : 1;
      dw = (proto != 2'h0) ? cw : (cmd == 8'h3b || cmd == 8'hbb) ? 2 : (cmd == 8'h6b || cmd == 8'heb) ? 4 : 1;
      nd = (cmd == 8'h03) ? 0 : (cmd == 8'hbb || cmd == 8'h6b) ? 7 : (cmd == 8'heb) ? 9 :
        (cmd == 8'h5a && proto == 2'h2) ? 10 : 8;
      oe_seen = 1'b0;
      sel_n = 1'b0;
      repeat (4) @(negedge core_clk);
      shift({16'h0, cmd}, 8, cw);
      shift(a, 24, aw);
      for (j = 0; j < nd + nb / dw; j = j + 1) begin
        host_q = ~host_q;
        tick;
        bits = (dw == 1) ? {3'h0, smp[1]} : smp & ~(4'hf << dw);
        if (j >= nd)
          rx[(j - nd) * dw / 8] = (rx[(j - nd) * dw / 8] << dw) | {4'h0, bits};
      end
      sel_n = 1'b1;
      repeat (8) @(negedge core_clk);
    end
  endtask
endmodule

// >>> tb/sfr_read_path_chk.sv
`timescale 1ns/1ps
module sfr_read_path_chk #(
  parameter ADDR_W = 24
) (
  input wire core_clk,
  input wire rstn,
  input wire sel_n,
  input wire sclk,
  input wire [1:0] proto,
  input wire [3:0] lane_out,
  input wire [3:0] lane_oe,
  input wire [ADDR_W-1:0] mem_addr,
  input wire busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  chk_idle_no_drive: assert property (sel_n [*6] |-> lane_oe == 4'h0)
    else $error("lanes driven after deselect");
  chk_idle_not_busy: assert property (sel_n [*6] |-> !busy)
    else $error("busy after deselect");
  chk_busy_needs_sel: assert property ($rose(busy) |-> !sel_n)
    else $error("busy rose while deselected");
  chk_drive_in_frame: assert property ($rose(|lane_oe) |-> !sel_n && busy)
    else $error("drive began outside a frame");
  chk_out_on_fall: assert property ((sclk && !sel_n) [*3] |-> $stable(lane_out))
    else $error("lane output moved while clock high");
  chk_addr_per_byte: assert property (busy && $changed(mem_addr) |=> $stable(mem_addr) [*6])
    else $error("address moved within a byte");
  chk_single_lanes: assert property (proto == 2'h0 |-> lane_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("bad lanes in single protocol");
  chk_dual_lanes: assert property (proto == 2'h1 |-> lane_oe inside {4'h0, 4'h3})
    else $error("bad lanes in dual protocol");
  chk_quad_lanes: assert property (proto == 2'h2 |-> lane_oe inside {4'h0, 4'hf})
    else $error("bad lanes in quad protocol");
endmodule

bind sfr_read_path sfr_read_path_chk #(.ADDR_W(ADDR_W)) u_sfr_read_path_chk (
  .core_clk(core_clk), .rstn(rstn), .sel_n(sel_n), .sclk(sclk), .proto(proto),
  .lane_out(lane_out), .lane_oe(lane_oe), .mem_addr(mem_addr), .busy(busy));

// >>> tb/sfr_read_path_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares = compares + 1; if ((a) !== (b)) begin err_count = err_count + 1; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module sfr_read_path_tb_top;
  reg core_clk = 1'b0;
  reg rstn = 1'b0;
  reg [1:0] proto = 2'h0;
  wire sel_n, sclk, busy, oe_seen;
  wire [3:0] lane_in, lane_out, lane_oe;
  wire [23:0] mem_addr;
  wire [31:0] got4;
  // Mixing top and low address bytes makes a lost upper address bit visible.
  wire [7:0] mem_data = mem_addr[7:0] ^ mem_addr[23:16];
  integer err_count = 0;
  integer compares = 0;
  integer i;
  // Row: refuse flag and protocol, command, address, four expected bytes.
  reg [67:0] rows [0:22] = '{68'h0_03_a50f3c_99989b9a, 68'h0_0b_fffffe_01000001, 68'h0_3b_5a0080_dadbd8d9,
    68'h0_bb_a50f3c_99989b9a, 68'h0_6b_fffffe_01000001, 68'h0_eb_5a0080_dadbd8d9, 68'h1_0b_a50f3c_99989b9a,
    68'h1_3b_fffffe_01000001, 68'h1_bb_5a0080_dadbd8d9, 68'h2_0b_5a0080_dadbd8d9, 68'h2_6b_a50f3c_99989b9a,
    68'h2_eb_fffffe_01000001, 68'h9_03_000000_00000000, 68'ha_3b_000000_00000000, 68'h9_6b_000000_00000000,
    68'ha_bb_000000_00000000, 68'h0_5a_000034_ffffff01, 68'h2_5a_000038_29eb276b, 68'h1_5a_00003c_083b27bb,
    68'h0_5a_000040_ffffffff, 68'h2_5a_000046_27bbffff, 68'h0_5a_00004c_0c2010d8, 68'h1_5a_00004e_10d80000};
  sfr_read_path u_sfr_read_path (.core_clk(core_clk), .rstn(rstn), .sel_n(sel_n), .sclk(sclk),
    .lane_in(lane_in), .lane_out(lane_out), .lane_oe(lane_oe), .proto(proto), .mem_addr(mem_addr),
    .mem_data(mem_data), .busy(busy));
  sfr_host_model u_sfr_host_model (.core_clk(core_clk), .proto(proto), .lane_out(lane_out),
    .lane_oe(lane_oe), .sel_n(sel_n), .sclk(sclk), .lane_in(lane_in), .got4(got4), .oe_seen(oe_seen));
  always #20 core_clk = ~core_clk;
  task wrap_up;
    begin
      $display("compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    rstn = 1'b1;
    repeat (3) @(negedge core_clk);
    `CHK({busy, lane_oe}, 5'h00)
    $display("reset test done");
    for (i = 0; i < 23; i = i + 1) begin
      proto = rows[i][65:64];
      u_sfr_host_model.frame(rows[i][63:56], rows[i][55:32], rows[i][67] ? 8 : 32);
      if (rows[i][67])
        `CHK(oe_seen, 1'b0)
      else
        `CHK(got4, rows[i][31:0])
      $display("row %0d done", i);
    end
    proto = 2'h0;
    u_sfr_host_model.frame(8'h5a, 24'h0007fe, 24);
    `CHK(got4[31:8], 24'hffff53)
    $display("table wrap test done");
    u_sfr_host_model.frame(8'h0b, 24'ha50f3c, 12);
    `CHK(got4[31:24], 8'h99)
    `CHK({busy, lane_oe}, 5'h00)
    // A frame cut in mid-byte must leave nothing behind for the next one.
    u_sfr_host_model.frame(8'h03, 24'h5a0080, 32);
    `CHK(got4, 32'hdadbd8d9)
    $display("abort test done");
    rstn = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK({busy, lane_oe, mem_addr}, 29'h0000000)
    rstn = 1'b1;
    repeat (3) @(negedge core_clk);
    u_sfr_host_model.frame(8'hbb, 24'ha50f3c, 32);
    `CHK(got4, 32'h99989b9a)
    $display("mid-run reset test done");
    wrap_up;
  end
  initial begin
    #3000000;
    err_count = err_count + 1;
    wrap_up;
  end
endmodule
